// ==== core/rail_sequencer.sv ====
`timescale 1ns/1ns
module rail_sequencer (
  // Clock, reset and enable.
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  // Configuration.
  input wire logic profile_b_i,
  input wire logic deep_sleep_or_enable_bit_i,
  // Supply state.
  input wire logic input_lockout_release_i,
  // Pins from the host side.
  input wire logic power_request_pin_i,
  input wire logic i2c_sleep_request_i,
  input wire logic pin_five_i,
  input wire logic pin_two_i,
  // Rail enables and status.
  output rail_seq_pkg::rail_set_s rail_en_o,
  output rail_seq_pkg::rail_set_s rail_power_ok_o,
  output logic deep_sleep_state_o,
  // Voltage setting selects: 1 primary, 0 alternate.
  output logic rail_one_primary_o,
  output logic rail_two_primary_o,
  // Open-drain pins, enable high while pulling low.
  output logic external_supply_enable_o,
  output logic external_supply_enable_oe_o,
  output logic pin_four_o,
  output logic pin_four_oe_o,
  output logic system_reset_out_n_o,
  output logic system_reset_out_n_oe_o,
  // I2C address the host-facing slave answers to.
  output logic [6:0] i2c_address_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Sequencer state and its next value.
  rail_seq_pkg::seq_state_e state;
  rail_seq_pkg::seq_state_e next_state;
  // Profile latched while off, so a change mid-run cannot tear the sequence.
  logic prof_b;
  // Combined deep sleep request.
  logic sleep_req;
  // Step triggers and the raw step outputs.
  logic run;
  rail_seq_pkg::rail_set_s trig;
  rail_seq_pkg::rail_set_s en_raw;
  rail_seq_pkg::rail_set_s ok_raw;
  // Delays and ramps chosen by profile.
  logic [rail_seq_pkg::CNT_W-1:0] dly [5];
  logic [rail_seq_pkg::CNT_W-1:0] rmp [5];
  logic [4:0] trig_v;
  logic [4:0] en_v;
  logic [4:0] ok_v;
  // Reset release from the delay timer.
  logic reset_released;
  logic [rail_seq_pkg::CNT_W-1:0] reset_cycles;

  ////////////////////////////////////////////////////////////////////////////
  // Deep sleep request. Profile B keeps deep sleep off entirely.
  always_comb begin
    sleep_req = 1'b0;
    if (!prof_b) begin
      // A low level on the request pin asks for sleep.
      sleep_req = !power_request_pin_i;
      if (deep_sleep_or_enable_bit_i) begin
        // The bus request counts only with the OR-enable set.
        sleep_req = sleep_req | i2c_sleep_request_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state machine.
  always_comb begin
    next_state = state;
    case (state)
      rail_seq_pkg::ST_OFF: begin
        if (input_lockout_release_i) begin
          // A low request at startup skips active mode.
          next_state = sleep_req ? rail_seq_pkg::ST_DEEP_SLEEP
                                 : rail_seq_pkg::ST_RUN;
        end
      end
      rail_seq_pkg::ST_RUN: begin
        if (!input_lockout_release_i) begin
          // Supply back in lockout: run-triggered rails drop at once, chained rails one cycle per link later.
          next_state = rail_seq_pkg::ST_OFF;
        end else if (sleep_req) begin
          // Any sleep request takes the whole tree down.
          next_state = rail_seq_pkg::ST_DEEP_SLEEP;
        end
      end
      rail_seq_pkg::ST_DEEP_SLEEP: begin
        if (!input_lockout_release_i) begin
          next_state = rail_seq_pkg::ST_OFF;
        end else if (!sleep_req) begin
          // Wake as soon as nothing asks for sleep.
          next_state = rail_seq_pkg::ST_RUN;
        end
      end
      // Unused codes fall back to off, the safe state.
      default: begin
        next_state = rail_seq_pkg::ST_OFF;
      end
    endcase
  end

  // State register.
  // A low clock enable holds the sequence where it is.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= rail_seq_pkg::ST_OFF;
    end else if (enable_i) begin
      state <= next_state;
    end
  end

  // Profile is taken only while everything is off.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prof_b <= 1'b0;
    end else if (enable_i && state == rail_seq_pkg::ST_OFF) begin
      // A new profile needs a full pass through off.
      prof_b <= profile_b_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step triggers. In deep sleep the whole tree drops; the per-rail sleep
  // levels are analog settings outside this logic, a deliberate simplification.
  assign run = (state == rail_seq_pkg::ST_RUN);

  always_comb begin
    trig = '0;
    if (!prof_b) begin
      trig.rail_two = run;
      trig.linear_one = run;
      trig.linear_two = run;
      trig.rail_one = run;
      // Rail three waits for rail one to be good.
      trig.rail_three = ok_raw.rail_one;
    end else begin
      trig.rail_two = run;
      trig.linear_two = ok_raw.rail_two;
      trig.rail_three = ok_raw.linear_two;
      // Rail one follows the external power good level.
      trig.rail_one = run && pin_five_i;
      // Linear one is unused in this profile.
      trig.linear_one = 1'b0;
    end
  end

  // Delay and ramp per step, index order: rail one, two, three, linear one, two.
  always_comb begin
    if (!prof_b) begin
      dly[0] = rail_seq_pkg::CNT_W'(rail_seq_pkg::A_RAIL_ONE_DELAY_CYC);
      // Rail two and linear one start with the state.
      dly[1] = '0;
      dly[2] = rail_seq_pkg::CNT_W'(rail_seq_pkg::A_RAIL_THREE_DELAY_CYC);
      dly[3] = '0;
      dly[4] = rail_seq_pkg::CNT_W'(rail_seq_pkg::A_LINEAR_TWO_DELAY_CYC);
      rmp[0] = rail_seq_pkg::CNT_W'(rail_seq_pkg::A_RAIL_ONE_RAMP_CYC);
      rmp[1] = rail_seq_pkg::CNT_W'(rail_seq_pkg::RAIL_TWO_RAMP_A_CYC);
      rmp[2] = rail_seq_pkg::CNT_W'(rail_seq_pkg::A_RAIL_THREE_RAMP_CYC);
      rmp[3] = rail_seq_pkg::CNT_W'(rail_seq_pkg::LINEAR_ONE_RAMP_CYC);
      rmp[4] = rail_seq_pkg::CNT_W'(rail_seq_pkg::A_LINEAR_TWO_RAMP_CYC);
    end else begin
      // The chain gives the order, so only short gaps remain.
      dly[0] = '0;
      dly[1] = '0;
      dly[2] = rail_seq_pkg::CNT_W'(rail_seq_pkg::B_RAIL_THREE_DELAY_CYC);
      dly[3] = '0;
      dly[4] = rail_seq_pkg::CNT_W'(rail_seq_pkg::B_LINEAR_TWO_DELAY_CYC);
      rmp[0] = rail_seq_pkg::CNT_W'(rail_seq_pkg::B_RAIL_ONE_RAMP_CYC);
      rmp[1] = rail_seq_pkg::CNT_W'(rail_seq_pkg::B_RAIL_TWO_RAMP_CYC);
      rmp[2] = rail_seq_pkg::CNT_W'(rail_seq_pkg::B_RAIL_THREE_RAMP_CYC);
      rmp[3] = rail_seq_pkg::CNT_W'(rail_seq_pkg::LINEAR_ONE_RAMP_CYC);
      rmp[4] = rail_seq_pkg::CNT_W'(rail_seq_pkg::B_LINEAR_TWO_RAMP_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One timed step per rail, all counted on this clock.
  assign trig_v = {trig.linear_two, trig.linear_one, trig.rail_three, trig.rail_two,
                   trig.rail_one};

  // Steps run side by side; the trigger tree sets the order.
  generate
    for (genvar i = 0; i < 5; i++) begin : g_step
      step_timer u_step (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .enable_i(enable_i),
        .trigger_i(trig_v[i]),
        .delay_i(dly[i]),
        .ramp_i(rmp[i]),
        .rail_en_o(en_v[i]),
        .power_ok_o(ok_v[i])
      );
    end
  endgenerate

  // Repack the step outputs in the carrier's field order.
  assign en_raw = {en_v[0], en_v[1], en_v[2], en_v[3], en_v[4]};
  assign ok_raw = {ok_v[0], ok_v[1], ok_v[2], ok_v[3], ok_v[4]};

  ////////////////////////////////////////////////////////////////////////////
  // System reset release, gated by rail two good.
  assign reset_cycles = prof_b ? rail_seq_pkg::CNT_W'(rail_seq_pkg::B_RESET_DELAY_CYC)
                               : rail_seq_pkg::CNT_W'(rail_seq_pkg::A_RESET_DELAY_CYC);

  // Losing rail two good pulls the reset low again.
  reset_delay u_reset (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .enable_i(enable_i),
    .gate_ok_i(ok_raw.rail_two),
    .delay_i(reset_cycles),
    .released_o(reset_released)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rail_en_o <= '0;
      rail_power_ok_o <= '0;
      deep_sleep_state_o <= 1'b0;
    end else if (enable_i) begin
      rail_en_o <= en_raw;
      rail_power_ok_o <= ok_raw;
      // Taken from the next state to save a cycle of lag.
      deep_sleep_state_o <= (next_state == rail_seq_pkg::ST_DEEP_SLEEP);
    end
  end

  // Voltage selects. Rail one's select is latched only while it is off; the
  // host must hold it steady anyway, this merely keeps a glitch harmless.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rail_one_primary_o <= 1'b1;
      rail_two_primary_o <= 1'b1;
    end else if (enable_i) begin
      // Once rail one is up its select no longer moves.
      if (!en_raw.rail_one) begin
        rail_one_primary_o <= prof_b ? 1'b1 : pin_five_i;
      end
      // Pin scaling only in profile B; profile A pins it to primary.
      rail_two_primary_o <= prof_b ? pin_two_i : 1'b1;
    end
  end

  // Open-drain pins: output value is always low, enable pulls the line.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      external_supply_enable_o <= 1'b0;
      external_supply_enable_oe_o <= 1'b1;
      pin_four_o <= 1'b0;
      pin_four_oe_o <= 1'b1;
      system_reset_out_n_o <= 1'b0;
      system_reset_out_n_oe_o <= 1'b1;
    end else if (enable_i) begin
      // Profile B has no supply enable; the pin stays pulled low.
      external_supply_enable_oe_o <= prof_b | !ok_raw.rail_one;
      // Profile A does not use pin four as power-good; it floats there.
      pin_four_oe_o <= prof_b & !ok_raw.rail_three;
      // Reset stays pulled low until the delay runs out.
      system_reset_out_n_oe_o <= !reset_released;
    end
  end

  // Address handed to the host-facing I2C slave.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      i2c_address_o <= rail_seq_pkg::I2C_ADDR;
    end else begin
      // Kept in a flip-flop so every output is registered.
      i2c_address_o <= rail_seq_pkg::I2C_ADDR;
    end
  end

endmodule : rail_sequencer

// ==== core/rail_seq_pkg.sv ====
package rail_seq_pkg;

  // Clock rate of the sequencer time base, in kHz.
  localparam int unsigned CLOCK_KHZ = 50000;

  // Times in microseconds, as printed.
  localparam int unsigned LINEAR_ONE_RAMP_US = 200;
  localparam int unsigned A_LINEAR_TWO_DELAY_US = 500;
  localparam int unsigned A_LINEAR_TWO_RAMP_US = 200;
  localparam int unsigned A_RAIL_ONE_DELAY_US = 1000;
  localparam int unsigned A_RAIL_ONE_RAMP_US = 500;
  localparam int unsigned A_RAIL_THREE_DELAY_US = 1000;
  localparam int unsigned A_RAIL_THREE_RAMP_US = 500;
  localparam int unsigned RAIL_TWO_RAMP_A_US = 250;
  localparam int unsigned B_RAIL_TWO_RAMP_US = 500;
  localparam int unsigned B_LINEAR_TWO_RAMP_US = 200;
  localparam int unsigned B_RAIL_THREE_RAMP_US = 500;
  localparam int unsigned B_RAIL_ONE_RAMP_US = 500;
  // Chained delays of profile B in tenths of a microsecond (0.5 and 1).
  localparam int unsigned B_LINEAR_TWO_DELAY_DUS = 5;
  localparam int unsigned B_RAIL_THREE_DELAY_DUS = 10;
  // Reset release delays in milliseconds.
  localparam int unsigned A_RESET_DELAY_MS = 10;
  localparam int unsigned B_RESET_DELAY_MS = 5;

  // Cycle counts; least times round up.
  localparam int unsigned CYC_PER_US = CLOCK_KHZ / 1000;
  localparam int unsigned LINEAR_ONE_RAMP_CYC = LINEAR_ONE_RAMP_US * CYC_PER_US;
  localparam int unsigned A_LINEAR_TWO_DELAY_CYC = A_LINEAR_TWO_DELAY_US * CYC_PER_US;
  localparam int unsigned A_LINEAR_TWO_RAMP_CYC = A_LINEAR_TWO_RAMP_US * CYC_PER_US;
  localparam int unsigned A_RAIL_ONE_DELAY_CYC = A_RAIL_ONE_DELAY_US * CYC_PER_US;
  localparam int unsigned A_RAIL_ONE_RAMP_CYC = A_RAIL_ONE_RAMP_US * CYC_PER_US;
  localparam int unsigned A_RAIL_THREE_DELAY_CYC = A_RAIL_THREE_DELAY_US * CYC_PER_US;
  localparam int unsigned A_RAIL_THREE_RAMP_CYC = A_RAIL_THREE_RAMP_US * CYC_PER_US;
  localparam int unsigned RAIL_TWO_RAMP_A_CYC = RAIL_TWO_RAMP_A_US * CYC_PER_US;
  localparam int unsigned B_RAIL_TWO_RAMP_CYC = B_RAIL_TWO_RAMP_US * CYC_PER_US;
  localparam int unsigned B_LINEAR_TWO_RAMP_CYC = B_LINEAR_TWO_RAMP_US * CYC_PER_US;
  localparam int unsigned B_RAIL_THREE_RAMP_CYC = B_RAIL_THREE_RAMP_US * CYC_PER_US;
  localparam int unsigned B_RAIL_ONE_RAMP_CYC = B_RAIL_ONE_RAMP_US * CYC_PER_US;
  localparam int unsigned B_LINEAR_TWO_DELAY_CYC = (B_LINEAR_TWO_DELAY_DUS * CYC_PER_US + 9) / 10;
  localparam int unsigned B_RAIL_THREE_DELAY_CYC = (B_RAIL_THREE_DELAY_DUS * CYC_PER_US + 9) / 10;
  localparam int unsigned A_RESET_DELAY_CYC = A_RESET_DELAY_MS * CLOCK_KHZ;
  localparam int unsigned B_RESET_DELAY_CYC = B_RESET_DELAY_MS * CLOCK_KHZ;

  // Width of every delay and ramp counter.
  localparam int unsigned CNT_W = 20;

  // Reset value of the deep sleep OR-enable in profile A.
  localparam logic DEEP_SLEEP_OR_ENABLE_RESET = 1'b1;
  // Responding 7-bit I2C address and its two bus bytes.
  localparam logic [6:0] I2C_ADDR = 7'h25;
  localparam logic [7:0] I2C_WRITE_BYTE = 8'h4a;
  localparam logic [7:0] I2C_READ_BYTE = 8'h4b;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RUN = 3'b001,
    ST_DEEP_SLEEP = 3'b010
  } seq_state_e;

  // Per-rail enables and power-ok indications.
  typedef struct packed {
    logic rail_one;
    logic rail_two;
    logic rail_three;
    logic linear_one;
    logic linear_two;
  } rail_set_s;

endpackage : rail_seq_pkg

// ==== core/step_timer.sv ====
`timescale 1ns/1ns
// One sequence step: waits a start delay after its trigger, then enables its
// rail and signals power-ok once the soft-start ramp has run.
module step_timer (
  // Clock, reset and enable.
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  // Control.
  input wire logic trigger_i,
  input wire logic [rail_seq_pkg::CNT_W-1:0] delay_i,
  input wire logic [rail_seq_pkg::CNT_W-1:0] ramp_i,
  // Status.
  output logic rail_en_o,
  output logic power_ok_o
);

  // Counts cycles of the start delay, then from zero through the ramp; holds once the step is done.
  logic [rail_seq_pkg::CNT_W-1:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // Dropping the trigger clears the step at once, so shutdown has no delay.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
      rail_en_o <= 1'b0;
      power_ok_o <= 1'b0;
    end else if (enable_i) begin
      if (!trigger_i) begin
        count <= '0;
        rail_en_o <= 1'b0;
        power_ok_o <= 1'b0;
      end else if (!rail_en_o) begin
        // Still in the start delay.
        if (count >= delay_i) begin
          rail_en_o <= 1'b1;
          count <= '0;
        end else begin
          count <= count + 1'b1;
        end
      end else if (!power_ok_o) begin
        // Ramp in progress.
        if (count + 1'b1 >= ramp_i) begin
          power_ok_o <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule : step_timer

// ==== core/reset_delay.sv ====
`timescale 1ns/1ns
// Holds a reset low until its gate is good, then releases it after a count.
module reset_delay (
  // Clock, reset and enable.
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  // Control.
  input wire logic gate_ok_i,
  input wire logic [rail_seq_pkg::CNT_W-1:0] delay_i,
  // Status.
  output logic released_o
);

  // Cycles spent with the gate good.
  logic [rail_seq_pkg::CNT_W-1:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // Losing the gate re-asserts the reset straight away.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
      released_o <= 1'b0;
    end else if (enable_i) begin
      if (!gate_ok_i) begin
        count <= '0;
        released_o <= 1'b0;
      end else if (!released_o) begin
        if (count + 1'b1 >= delay_i) begin
          released_o <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule : reset_delay

// ==== sim/host_pins.sv ====
`timescale 1ns/1ns
// Host and supply side: pull-ups on the open-drain lines and the pin five driver.
module host_pins (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic resetn_i,
  // Bench stimulus.
  input wire logic profile_b_i,
  input wire logic select_i,
  input wire logic ext_good_i,
  // Device side.
  input wire logic rails_on_i,
  input wire logic supply_oe_i,
  input wire logic pin_four_oe_i,
  input wire logic reset_oe_i,
  output logic pin_five_o,
  output logic supply_line_o,
  output logic pin_four_line_o,
  output logic reset_line_o
);
  logic held_select; // Select level applied while every rail was off.

  //////////////////////////////////////////////////////////////////////////////
  // The host only moves the select while all rails are off, so a late change waits.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      held_select <= 1'b1;
    end else if (!rails_on_i) begin
      held_select <= select_i;
    end
  end

  // Profile B reuses pin five as the external power good input.
  assign pin_five_o = profile_b_i ? ext_good_i : held_select;
  // Pull-ups make every released line high.
  assign supply_line_o = ~supply_oe_i;
  assign pin_four_line_o = ~pin_four_oe_i;
  assign reset_line_o = ~reset_oe_i;
endmodule : host_pins

// ==== sim/rail_sequencer_properties.sv ====
`timescale 1ns/1ns
// Port-level relations of the rail sequencer.
module rail_sequencer_properties (
  // Clock, reset and enable.
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  // Configuration and host pins.
  input wire logic profile_b_i,
  input wire logic deep_sleep_or_enable_bit_i,
  input wire logic input_lockout_release_i,
  input wire logic power_request_pin_i,
  input wire logic i2c_sleep_request_i,
  input wire logic pin_five_i,
  input wire logic pin_two_i,
  // Watched outputs.
  input wire rail_seq_pkg::rail_set_s rail_en_o,
  input wire rail_seq_pkg::rail_set_s rail_power_ok_o,
  input wire logic deep_sleep_state_o,
  input wire logic rail_one_primary_o,
  input wire logic rail_two_primary_o,
  input wire logic external_supply_enable_oe_o,
  input wire logic pin_four_oe_o,
  input wire logic system_reset_out_n_oe_o,
  input wire logic [6:0] i2c_address_o
);
  logic [16:0] since_l1; // Cycles since linear one came on; both share one trigger.

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  //////////////////////////////////////////////////////////////////////////////
  // Counting from an output avoids guessing the body's internal pipeline.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      since_l1 <= 17'h0;
    end else if (!rail_en_o.linear_one) begin
      since_l1 <= 17'h0;
    end else if (enable_i) begin
      since_l1 <= since_l1 + 17'h1;
    end
  end

  chk_step_pair: assert property (
    $rose(rail_en_o.linear_one) && !profile_b_i |-> rail_en_o.rail_two)
    else $error("Linear one on without rail two.");
  chk_linear_two_delay: assert property (
    $rose(rail_en_o.linear_two) && !profile_b_i |-> since_l1 == 17'h61a8)
    else $error("Linear two start delay wrong.");
  chk_rail_one_delay: assert property (
    $rose(rail_en_o.rail_one) && !profile_b_i |-> since_l1 == 17'hc350)
    else $error("Rail one start delay wrong.");
  chk_supply_release: assert property (
    $rose(rail_power_ok_o.rail_one) && !profile_b_i |-> ##[0:1] !external_supply_enable_oe_o)
    else $error("Supply enable not released.");
  chk_sleep_pin: assert property (
    (enable_i && input_lockout_release_i && !profile_b_i && !power_request_pin_i)[*3]
    |-> deep_sleep_state_o)
    else $error("Low request pin without deep sleep.");
  chk_sleep_bus: assert property (
    (enable_i && input_lockout_release_i && !profile_b_i && i2c_sleep_request_i
    && deep_sleep_or_enable_bit_i)[*3] |-> deep_sleep_state_o)
    else $error("Bus sleep request ignored.");
  chk_b_no_sleep: assert property (
    profile_b_i [*3] |-> !deep_sleep_state_o)
    else $error("Deep sleep in profile B.");
  chk_shutdown_all: assert property (
    (enable_i && !input_lockout_release_i)[*4] |-> rail_en_o == 5'h0)
    else $error("Rail left on at shutdown.");
  chk_reset_hold: assert property (
    (!rail_power_ok_o.rail_two)[*3] |-> system_reset_out_n_oe_o)
    else $error("Reset released before rail two good.");
  chk_ext_good: assert property (
    (enable_i && profile_b_i && !pin_five_i)[*3] |-> !rail_en_o.rail_one)
    else $error("Rail one on without power good.");
  chk_scale_pin: assert property (
    (profile_b_i && input_lockout_release_i && $stable(pin_two_i))[*3]
    |-> rail_two_primary_o == pin_two_i)
    else $error("Rail two select does not follow pin two.");
  chk_select_a: assert property (
    (!profile_b_i && !rail_en_o.rail_one && $stable(pin_five_i))[*3]
    |-> rail_one_primary_o == pin_five_i)
    else $error("Rail one select does not follow pin five.");
  chk_pg_pin: assert property (
    (profile_b_i && !rail_power_ok_o.rail_three)[*3] |-> pin_four_oe_o)
    else $error("Pin four released early.");
  chk_bus_address: assert property (
    i2c_address_o == 7'h25)
    else $error("Bus address wrong.");

  cover property ($rose(deep_sleep_state_o));
  cover property ($rose(rail_power_ok_o.rail_one));
  cover property ($rose(rail_en_o.linear_two) && profile_b_i);
endmodule : rail_sequencer_properties

bind rail_sequencer rail_sequencer_properties chk_u (.clock_i, .resetn_i, .enable_i,
  .profile_b_i, .deep_sleep_or_enable_bit_i, .input_lockout_release_i, .power_request_pin_i,
  .i2c_sleep_request_i, .pin_five_i, .pin_two_i, .rail_en_o, .rail_power_ok_o,
  .deep_sleep_state_o, .rail_one_primary_o, .rail_two_primary_o,
  .external_supply_enable_oe_o, .pin_four_oe_o, .system_reset_out_n_oe_o, .i2c_address_o);

// ==== sim/tb.sv ====
`timescale 1ns/1ns
module tb;
  localparam int CPU = 50; // Clock cycles per microsecond at 50 MHz.
  logic clock_i = 1'b0;
  logic resetn_i = 1'b1;
  logic enable_i = 1'b1;
  logic profile_b_i = 1'b0;
  logic or_bit = 1'b1;
  logic lockout = 1'b0;
  logic power_req = 1'b1;
  logic i2c_req = 1'b0;
  logic pin_two = 1'b0;
  logic select = 1'b1;
  logic ext_good = 1'b0;
  logic pin_five, deep, r1_primary, r2_primary;
  logic supply_oe, pin_four_oe, reset_oe, supply_line, pin_four_line, reset_line;
  logic [6:0] address;
  logic [2:0] od_drive; // Driven levels of the open-drain pins.
  logic [11:0] obs; // Enables, power oks, deep sleep, supply line.
  rail_seq_pkg::rail_set_s rail_en, rail_ok;
  int failures = 0;
  int n_compared = 0;
  int n;

  always #10 clock_i = ~clock_i;
  assign obs = {rail_en, rail_ok, deep, supply_line};

  rail_sequencer dut_u (.clock_i, .resetn_i, .enable_i, .profile_b_i,
    .deep_sleep_or_enable_bit_i(or_bit), .input_lockout_release_i(lockout),
    .power_request_pin_i(power_req), .i2c_sleep_request_i(i2c_req), .pin_five_i(pin_five),
    .pin_two_i(pin_two), .rail_en_o(rail_en), .rail_power_ok_o(rail_ok),
    .deep_sleep_state_o(deep), .rail_one_primary_o(r1_primary),
    .rail_two_primary_o(r2_primary), .external_supply_enable_o(od_drive[2]),
    .external_supply_enable_oe_o(supply_oe), .pin_four_o(od_drive[1]),
    .pin_four_oe_o(pin_four_oe), .system_reset_out_n_o(od_drive[0]),
    .system_reset_out_n_oe_o(reset_oe), .i2c_address_o(address));

  host_pins host_u (.clock_i, .resetn_i, .profile_b_i, .select_i(select),
    .ext_good_i(ext_good), .rails_on_i(|rail_en), .supply_oe_i(supply_oe),
    .pin_four_oe_i(pin_four_oe), .reset_oe_i(reset_oe), .pin_five_o(pin_five),
    .supply_line_o(supply_line), .pin_four_line_o(pin_four_line), .reset_line_o(reset_line));

  //////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic final_report();
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check

  // Counts falling edges until an observed bit reaches a level; a hang ends the run.
  task automatic wait_lvl(input int idx, input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while (obs[idx] !== lvl && cnt < bound) begin
      @(negedge clock_i);
      cnt++;
    end
    if (obs[idx] !== lvl) begin
      failures++;
      $display("unexpected bit %0d: expected %0h, seen %0h", idx, lvl, obs[idx]);
      final_report();
    end
  endtask : wait_lvl

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_i = 1'b0;
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    check("reset line", 32'h0, reset_line);
    check("address", 32'h25, address);
    // Profile A: timed chain from lockout release.
    @(posedge clock_i);
    lockout <= 1'b1;
    wait_lvl(10, 1'b1, 8, n);
    check("linear one", 32'h1, rail_en.linear_one);
    wait_lvl(7, 1'b1, 30000, n);
    check("linear two delay", 500 * CPU, n);
    wait_lvl(11, 1'b1, 30000, n);
    check("rail one delay", 500 * CPU, n);
    wait_lvl(6, 1'b1, 30000, n);
    check("rail one ramp", 500 * CPU, n);
    wait_lvl(0, 1'b1, 3, n);
    check("supply lag", 32'h1, n <= 1);
    check("rail one select", 32'h1, r1_primary);
    check("rail two select", 32'h1, r2_primary);
    check("reset line", 32'h0, reset_line);
    // Sleep by pin drops every rail; the select is taken again meanwhile.
    @(posedge clock_i);
    power_req <= 1'b0;
    select <= 1'b0;
    wait_lvl(1, 1'b1, 4, n);
    repeat (4) @(negedge clock_i);
    check("sleep rails", 32'h0, rail_en);
    check("rail one select", 32'h0, r1_primary);
    @(posedge clock_i);
    enable_i <= 1'b0;
    power_req <= 1'b1;
    repeat (4) @(negedge clock_i);
    check("frozen sleep", 32'h1, deep);
    @(posedge clock_i);
    enable_i <= 1'b1;
    wait_lvl(1, 1'b0, 4, n);
    @(posedge clock_i);
    i2c_req <= 1'b1;
    wait_lvl(1, 1'b1, 4, n);
    @(posedge clock_i);
    i2c_req <= 1'b0;
    or_bit <= 1'b0;
    wait_lvl(1, 1'b0, 4, n);
    @(posedge clock_i);
    i2c_req <= 1'b1;
    repeat (6) @(negedge clock_i);
    check("masked bus sleep", 32'h0, deep);
    @(posedge clock_i);
    lockout <= 1'b0;
    repeat (4) @(negedge clock_i);
    check("shutdown rails", 32'h0, rail_en);
    // Low request pin at startup goes straight to sleep.
    @(posedge clock_i);
    i2c_req <= 1'b0;
    or_bit <= 1'b1;
    power_req <= 1'b0;
    lockout <= 1'b1;
    wait_lvl(1, 1'b1, 4, n);
    check("rails at sleep start", 32'h0, rail_en);
    @(posedge clock_i);
    lockout <= 1'b0;
    repeat (4) @(posedge clock_i);
    // Profile B: the sleep pin stays low and must be ignored.
    profile_b_i <= 1'b1;
    @(posedge clock_i);
    lockout <= 1'b1;
    wait_lvl(10, 1'b1, 8, n);
    check("deep in profile B", 32'h0, deep);
    check("rail two select", 32'h0, r2_primary);
    check("rail one gated", 32'h0, rail_en.rail_one);
    @(posedge clock_i);
    pin_two <= 1'b1;
    repeat (4) @(negedge clock_i);
    check("rail two select", 32'h1, r2_primary);
    wait_lvl(5, 1'b1, 30000, n);
    // The select check above already used four of the ramp's cycles.
    check("rail two ramp", 500 * CPU, n + 4);
    wait_lvl(7, 1'b1, 60, n);
    check("chain gap", 32'h1, n >= 25 && n <= 28);
    check("pin four line", 32'h0, pin_four_line);
    check("reset line", 32'h0, reset_line);
    @(posedge clock_i);
    ext_good <= 1'b1;
    wait_lvl(11, 1'b1, 6, n);
    @(posedge clock_i);
    ext_good <= 1'b0;
    wait_lvl(11, 1'b0, 6, n);
    check("open-drain drive", 32'h0, od_drive);
    final_report();
  end
endmodule : tb
